// File: pacp_pkg.sv
package pacp_pkg;

   // Attributes are applied per page; the line index must stay inside the page offset.
   localparam int unsigned PAGE_BYTES = 4096;
   localparam int unsigned PAGE_OFF_W = 12;
   localparam int unsigned BLK_OFF_W  = 2;
   localparam int unsigned IDX_W      = 2;
   localparam int unsigned LINES      = 4;
   localparam int unsigned TAG_W      = 32 - BLK_OFF_W - IDX_W;

   // Register offsets (byte addresses on the register bus).
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_HITS   = 12'h008;
   localparam logic [11:0] REG_WBACKS = 12'h00c;

   // Control fields and reset values.
   localparam int unsigned CTRL_THRU_BIT    = 0;
   localparam int unsigned CTRL_UNIFIED_BIT = 1;
   localparam logic [1:0]  CTRL_RST         = 2'h0;
   localparam logic [31:0] CNT_RST          = 32'h0;

   // Operations carried from the load/store pipeline.
   typedef enum logic [2:0] {
      OP_LOAD  = 3'h0,
      OP_STORE = 3'h1,
      OP_DCBST = 3'h2,
      OP_DCBF  = 3'h3,
      OP_ICBI  = 3'h4,
      OP_SYNC  = 3'h5
   } pacp_op_type;

   // Four page attributes: write-through, caching-inhibited, coherent, guarded.
   typedef struct packed {
      logic wt;
      logic ci;
      logic cr;
      logic gd;
   } pacp_attr_type;

   typedef struct packed {
      pacp_op_type   op;
      pacp_attr_type attr;
      logic          segment_type_bit;
      logic [31:0]   addr;
      logic [31:0]   wdata;
   } pacp_req_type;

   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pacp_mem_type;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_EXEC    = 3'h1,
      ST_OWN     = 3'h2,
      ST_WR      = 3'h3,
      ST_RD_REQ  = 3'h4,
      ST_RD_WAIT = 3'h5,
      ST_DONE    = 3'h6
   } pacp_state_type;

endpackage

// File: pacp_cache_policy.sv
`timescale 1ns/1ps
`default_nettype none
module pacp_cache_policy
   import pacp_pkg::*;
(
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Register bus.
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Load/store pipeline.
   input  wire logic         req_valid,
   input  wire pacp_req_type req,
   output logic              req_ready,
   output logic              rsp_valid,
   output logic [31:0]       rsp_data,
   // Main memory.
   output logic              mem_req_valid,
   output pacp_mem_type      mem_req,
   input  wire logic         mem_req_ready,
   input  wire logic         mem_rsp_valid,
   input  wire logic [31:0]  mem_rsp_data,
   // Store ownership and invalidation toward other processors.
   output logic              own_req,
   input  wire logic         own_gnt,
   output logic              inv_out_valid,
   output logic [31:0]       inv_out_addr,
   // Invalidations arriving from other processors and I/O.
   input  wire logic         snp_valid,
   input  wire logic [31:0]  snp_addr,
   output logic              snp_ready
);

   function automatic logic [IDX_W-1:0] line_idx(input logic [31:0] a);
      return a[BLK_OFF_W +: IDX_W];
   endfunction

   function automatic logic [TAG_W-1:0] line_tag(input logic [31:0] a);
      return a[31 -: TAG_W];
   endfunction

   function automatic logic [31:0] blk_addr(input logic [31:0] a);
      return {a[31:BLK_OFF_W], {BLK_OFF_W{1'b0}}};
   endfunction

   pacp_state_type    st_q;
   pacp_state_type    ret_q;
   pacp_req_type      req_q;
   pacp_mem_type      mem_q;
   logic              own_held_q;
   logic [1:0]        ctrl_q;
   logic [31:0]       hits_q;
   logic [31:0]       wbacks_q;
   logic [31:0]       prdata_q;
   logic [31:0]       rsp_q;
   logic [LINES-1:0]  valid_q;
   logic [LINES-1:0]  dirty_q;
   logic [TAG_W-1:0]  tag_q [LINES];
   logic [31:0]       data_q [LINES];

   logic [IDX_W-1:0]  idx;
   logic [IDX_W-1:0]  sidx;
   logic              hit;
   logic              dirty_hit;
   logic              victim_dirty;
   logic              snp_hit;
   logic              ex;
   logic              nop_cop;
   logic              need_own;
   logic              through;
   logic              snp_take;
   logic              unified;

   // Index bits lie inside the page offset, so aliases with equal offsets share a line.
   // per-page attributes
   assign idx          = line_idx(req_q.addr);
   assign sidx         = line_idx(snp_addr);
   assign hit          = valid_q[idx] && (tag_q[idx] == line_tag(req_q.addr));
   assign dirty_hit    = hit && dirty_q[idx];
   assign victim_dirty = valid_q[idx] && dirty_q[idx] && !hit;
   assign snp_hit      = valid_q[sidx] && (tag_q[sidx] == line_tag(snp_addr));
   assign ex           = (st_q == ST_EXEC);
   assign unified      = ctrl_q[CTRL_UNIFIED_BIT];
   assign snp_take     = (st_q == ST_IDLE) && snp_valid;
   assign nop_cop      = req_q.segment_type_bit &&
                         (req_q.op == OP_DCBST || req_q.op == OP_DCBF || req_q.op == OP_ICBI);
   assign need_own     = (req_q.op == OP_STORE) && req_q.attr.cr && !own_held_q;
   assign through      = (req_q.attr.wt && !req_q.attr.ci) || ctrl_q[CTRL_THRU_BIT];

   // Handshakes; snoops take priority over new requests, but wait until the request in flight finishes.
   assign req_ready     = (st_q == ST_IDLE) && !snp_valid;
   assign snp_ready     = (st_q == ST_IDLE);
   assign rsp_valid     = (st_q == ST_DONE);
   assign rsp_data      = rsp_q;
   assign mem_req_valid = (st_q == ST_WR) || (st_q == ST_RD_REQ);
   assign mem_req       = mem_q;
   assign own_req       = (st_q == ST_OWN) || own_held_q;
   assign inv_out_valid = ex && !nop_cop && req_q.attr.cr &&
                          (req_q.op == OP_DCBF || (req_q.op == OP_ICBI && !unified));
   assign inv_out_addr  = blk_addr(req_q.addr);

   // Sequencer; one request at a time keeps every access in program order.
   // in-order execution
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q  <= ST_IDLE;
         ret_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (snp_take && snp_hit && dirty_q[sidx]) begin
                  st_q  <= ST_WR;
                  ret_q <= ST_IDLE;
               end else if (req_valid && req_ready) begin
                  st_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (nop_cop || req_q.op == OP_SYNC || req_q.op == OP_ICBI) begin
                  st_q <= ST_DONE;
               end else if (need_own) begin
                  st_q <= ST_OWN;
               end else if (req_q.op == OP_LOAD) begin
                  if (req_q.attr.ci || (!hit && !victim_dirty)) begin
                     st_q <= ST_RD_REQ;
                  end else if (hit) begin
                     st_q <= ST_DONE;
                  end else begin
                     st_q  <= ST_WR;
                     ret_q <= ST_EXEC;
                  end
               end else if (req_q.op == OP_STORE) begin
                  if (!req_q.attr.ci && victim_dirty) begin
                     st_q  <= ST_WR;
                     ret_q <= ST_EXEC;
                  end else if (req_q.attr.ci || through) begin
                     st_q  <= ST_WR;
                     ret_q <= ST_DONE;
                  end else begin
                     st_q <= ST_DONE;
                  end
               end else if (req_q.op == OP_DCBST) begin
                  if (hit && (dirty_q[idx] || req_q.attr.cr)) begin
                     st_q  <= ST_WR;
                     ret_q <= ST_DONE;
                  end else begin
                     st_q <= ST_DONE;
                  end
               end else begin
                  if (dirty_hit) begin
                     st_q  <= ST_WR;
                     ret_q <= ST_DONE;
                  end else begin
                     st_q <= ST_DONE;
                  end
               end
            end
            ST_OWN: begin
               if (own_gnt) begin
                  st_q <= ST_EXEC;
               end
            end
            ST_WR: begin
               if (mem_req_ready) begin
                  st_q <= ret_q;
               end
            end
            ST_RD_REQ: begin
               if (mem_req_ready) begin
                  st_q <= ST_RD_WAIT;
               end
            end
            ST_RD_WAIT: begin
               if (mem_rsp_valid) begin
                  st_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Request capture and store ownership, held only for the store that asked for it.
   // attributes per access
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         req_q      <= '0;
         own_held_q <= 1'b0;
      end else begin
         if (req_valid && req_ready) begin
            req_q <= req;
         end
         if (st_q == ST_OWN && own_gnt) begin
            own_held_q <= 1'b1;
         end else if (st_q == ST_DONE) begin
            own_held_q <= 1'b0;
         end
      end
   end

   // Memory request word, loaded on the edge that enters a write or read state.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_q <= '0;
      end else if (snp_take && snp_hit && dirty_q[sidx]) begin
         mem_q <= '{we: 1'b1, addr: {tag_q[sidx], sidx, {BLK_OFF_W{1'b0}}}, wdata: data_q[sidx]};
      end else if (ex && !nop_cop && !need_own) begin
         if (victim_dirty && !req_q.attr.ci && (req_q.op == OP_LOAD || req_q.op == OP_STORE)) begin
            mem_q <= '{we: 1'b1, addr: {tag_q[idx], idx, {BLK_OFF_W{1'b0}}}, wdata: data_q[idx]};
         end else if (req_q.op == OP_LOAD) begin
            mem_q <= '{we: 1'b0, addr: blk_addr(req_q.addr), wdata: 32'h0};
         end else if (req_q.op == OP_STORE) begin
            mem_q <= '{we: 1'b1, addr: blk_addr(req_q.addr), wdata: req_q.wdata};
         end else begin
            mem_q <= '{we: 1'b1, addr: blk_addr(req_q.addr), wdata: data_q[idx]};
         end
      end
   end

   // Cache lines; inhibited accesses never touch them.
   // cacheable accesses use the lines
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         valid_q <= '0;
         dirty_q <= '0;
         for (int i = 0; i < LINES; i++) begin
            tag_q[i]  <= '0;
            data_q[i] <= 32'h0;
         end
      end else if (snp_take) begin
         if (snp_hit) begin
            valid_q[sidx] <= 1'b0;
            dirty_q[sidx] <= 1'b0;
         end
      end else if (ex && !nop_cop && !need_own && !req_q.attr.ci) begin
         if (victim_dirty && (req_q.op == OP_LOAD || req_q.op == OP_STORE)) begin
            valid_q[idx] <= 1'b0;
            dirty_q[idx] <= 1'b0;
         end else if (req_q.op == OP_STORE) begin
            valid_q[idx] <= 1'b1;
            dirty_q[idx] <= !through;
            tag_q[idx]   <= line_tag(req_q.addr);
            data_q[idx]  <= req_q.wdata;
         end else if (req_q.op == OP_DCBST && hit) begin
            dirty_q[idx] <= 1'b0;
         end else if (req_q.op == OP_DCBF && hit) begin
            valid_q[idx] <= 1'b0;
            dirty_q[idx] <= 1'b0;
         end
      end else if (st_q == ST_RD_WAIT && mem_rsp_valid && !req_q.attr.ci) begin
         valid_q[idx] <= 1'b1;
         dirty_q[idx] <= 1'b0;
         tag_q[idx]   <= line_tag(req_q.addr);
         data_q[idx]  <= mem_rsp_data;
      end
   end

   // Load data to the pipeline.
   // hit returns cached data
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_q <= 32'h0;
      end else if (ex && req_q.op == OP_LOAD && !req_q.attr.ci && hit) begin
         rsp_q <= data_q[idx];
      end else if (st_q == ST_RD_WAIT && mem_rsp_valid) begin
         rsp_q <= mem_rsp_data;
      end
   end

   // Activity counters let software see how the policy behaves.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hits_q   <= CNT_RST;
         wbacks_q <= CNT_RST;
      end else begin
         if (ex && hit && !nop_cop && !need_own &&
             (req_q.op == OP_LOAD || req_q.op == OP_STORE) && !req_q.attr.ci) begin
            hits_q <= hits_q + 32'h1;
         end
         if (st_q == ST_WR && mem_req_ready) begin
            wbacks_q <= wbacks_q + 32'h1;
         end
      end
   end

   // Register bus slave: zero wait states, read data latched in the setup cycle.
   logic bus_known;
   assign bus_known = (paddr[11:0] == REG_CTRL) || (paddr[11:0] == REG_STATUS) ||
                      (paddr[11:0] == REG_HITS) || (paddr[11:0] == REG_WBACKS);
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && (!bus_known || (pwrite && paddr[11:0] != REG_CTRL));
   assign prdata    = prdata_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q   <= CTRL_RST;
         prdata_q <= 32'h0;
      end else begin
         if (psel && penable && pwrite && paddr[11:0] == REG_CTRL) begin
            ctrl_q <= pwdata[1:0];
         end
         if (psel && !penable) begin
            case (paddr[11:0])
               REG_CTRL:   prdata_q <= {30'h0, ctrl_q};
               REG_STATUS: prdata_q <= {28'h0, own_held_q, st_q};
               REG_HITS:   prdata_q <= hits_q;
               REG_WBACKS: prdata_q <= wbacks_q;
               default:    prdata_q <= 32'h0;
            endcase
         end
      end
   end

   sequence s_wb_issue;
      st_q == ST_WR && mem_req.we;
   endsequence

   sequence s_respond;
      st_q == ST_DONE && rsp_valid;
   endsequence

   a_store_through: assert property (@(posedge clk) disable iff (!arst_n)
      ex && req_q.op == OP_STORE && !req_q.attr.ci && through && !need_own && !victim_dirty
      |=> s_wb_issue and mem_req.wdata == $past(req_q.wdata))
      else $error("write-through store did not reach memory");

   a_load_hit: assert property (@(posedge clk) disable iff (!arst_n)
      ex && req_q.op == OP_LOAD && !req_q.attr.ci && hit
      |=> s_respond and rsp_data == $past(data_q[idx]) and !mem_req_valid)
      else $error("load hit not served from cache");

   a_wback_local: assert property (@(posedge clk) disable iff (!arst_n)
      ex && req_q.op == OP_STORE && !req_q.attr.ci && !through && !need_own && !victim_dirty
      |=> s_respond ##1 st_q == ST_IDLE)
      else $error("write-back store went to memory");

   a_ci_bypass: assert property (@(posedge clk) disable iff (!arst_n)
      st_q == ST_RD_WAIT && mem_rsp_valid && req_q.attr.ci
      |=> valid_q == $past(valid_q) and rsp_data == $past(mem_rsp_data))
      else $error("inhibited load touched the cache");

   a_dstore_nop: assert property (@(posedge clk) disable iff (!arst_n)
      ex && nop_cop |-> !inv_out_valid ##1 s_respond)
      else $error("direct-store cache operation had an effect");

   a_own_before: assert property (@(posedge clk) disable iff (!arst_n)
      st_q == ST_WR && ret_q == ST_DONE && req_q.op == OP_STORE && req_q.attr.cr |-> own_held_q)
      else $error("coherent store issued without ownership");

   a_flush_dirty: assert property (@(posedge clk) disable iff (!arst_n)
      ex && req_q.op == OP_DCBF && !nop_cop && dirty_hit
      |=> s_wb_issue and !valid_q[$past(idx)])
      else $error("flush of modified block not written back");

   a_clean_nc: assert property (@(posedge clk) disable iff (!arst_n)
      ex && req_q.op == OP_DCBST && !nop_cop && !req_q.attr.cr && !dirty_hit |=> s_respond)
      else $error("clean non-coherent block written back");

   a_read_order: assert property (@(posedge clk) disable iff (!arst_n)
      mem_req_valid && !mem_req.we |-> mem_req.addr == blk_addr(req_q.addr))
      else $error("memory read not for the current request");

   a_sync_drain: assert property (@(posedge clk) disable iff (!arst_n)
      rsp_valid && req_q.op == OP_SYNC |-> !mem_req_valid && $past(st_q) == ST_EXEC)
      else $error("synchronize answered with memory pending");

endmodule
`default_nettype wire

// File: pacp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pacp_mem_model
   import pacp_pkg::*;
(
   // Clock, reset and pacing.
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         slow,
   // Memory side.
   input  wire logic         mem_req_valid,
   input  wire pacp_mem_type mem_req,
   output logic              mem_req_ready,
   output logic              mem_rsp_valid,
   output logic [31:0]       mem_rsp_data,
   // Store ownership.
   input  wire logic         own_req,
   output logic              own_gnt
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] wlog [$];
   logic [31:0] rd_q;
   logic [31:0] wa;
   int          wr_n;
   int          rd_n;
   int          cyc;
   int          pend;
   // Slow mode opens each handshake one cycle in four, so the block must hold its requests.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_req_ready <= 1'b0;
         mem_rsp_valid <= 1'b0;
         mem_rsp_data  <= 32'h0;
         own_gnt       <= 1'b0;
         pend          <= 0;
         cyc           <= 0;
      end else begin
         wa = {mem_req.addr[31:2], 2'h0};
         cyc           <= cyc + 1;
         mem_req_ready <= !slow || (cyc % 4 == 2);
         mem_rsp_valid <= 1'b0;
         // A released data line never repeats the last word.
         mem_rsp_data  <= ~mem_rsp_data;
         own_gnt       <= own_req && (!slow || (cyc % 4 == 1));
         if (pend > 0) begin
            pend <= pend - 1;
         end
         if (pend == 1) begin
            mem_rsp_valid <= 1'b1;
            mem_rsp_data  <= rd_q;
         end
         if (mem_req_valid && mem_req_ready) begin
            if (mem_req.we) begin
               mem[wa] = mem_req.wdata;
               wlog.push_back(mem_req.wdata);
               wr_n++;
            end else begin
               rd_q <= mem.exists(wa) ? mem[wa] : ~wa;
               pend <= slow ? 3 : 1;
               rd_n++;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: test_page_attribute_cache_policy.sv
`timescale 1ns/1ps
`default_nettype none
module test_page_attribute_cache_policy
   import pacp_pkg::*;
;
   logic         clk, arst_n, psel, penable, pwrite, perr, slow;
   logic         pready, pslverr, req_valid, req_ready, rsp_valid, mem_req_valid;
   logic         mem_req_ready, mem_rsp_valid, own_req, own_gnt, inv_out_valid;
   logic         snp_valid, snp_ready;
   logic [31:0]  paddr, pwdata, prdata, rsp_data, mem_rsp_data, inv_out_addr, snp_addr;
   logic [31:0]  seed, prd, d, a, r, cur_a;
   logic [32:0]  note;
   logic [32:0]  expq [$];
   pacp_req_type req;
   pacp_mem_type mem_req;
   int           errors, comparisons, cycles, inv_n, rsp_n, we, wr, wi;

   pacp_cache_policy u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_req_valid(mem_req_valid),
      .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
      .mem_rsp_data(mem_rsp_data), .own_req(own_req), .own_gnt(own_gnt),
      .inv_out_valid(inv_out_valid), .inv_out_addr(inv_out_addr), .snp_valid(snp_valid),
      .snp_addr(snp_addr), .snp_ready(snp_ready));

   pacp_mem_model mm (.clk(clk), .arst_n(arst_n), .slow(slow), .mem_req_valid(mem_req_valid),
      .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
      .mem_rsp_data(mem_rsp_data), .own_req(own_req), .own_gnt(own_gnt));

   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Outputs are sampled on the falling edge, where they have settled.
   always @(negedge clk) begin
      if (inv_out_valid === 1'b1) begin
         inv_n++;
         chk("inv_addr", {cur_a[31:2], 2'h0}, inv_out_addr);
      end
      if (rsp_valid === 1'b1) begin
         rsp_n++;
         note = expq.size() > 0 ? expq.pop_front() : {1'b1, 32'hdead0bad};
         if (note[32]) begin
            chk("rsp_data", note[31:0], rsp_data);
         end
      end
   end

   // A hang ends the run as a failure.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   // One request, then the memory traffic and invalidations it caused are counted.
   task automatic op(input pacp_op_type o, input logic [3:0] at, input logic stb,
                     input logic [31:0] ad, dat, input logic c, input logic [31:0] e,
                     input int dw, dr, di);
      int n;
      n = rsp_n;
      we += dw;
      wr += dr;
      wi += di;
      cur_a = ad;
      expq.push_back({c, e});
      @(posedge clk);
      req_valid <= 1'b1;
      req       <= {o, at, stb, ad, dat};
      // The request is taken at the rising edge that sees the ready high.
      do @(posedge clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      req       <= ~{o, at, stb, ad, dat};
      while (rsp_n == n) @(negedge clk);
      chk("mem_writes", we, mm.wr_n);
      chk("mem_reads", wr, mm.rd_n);
      chk("invalidates", wi, inv_n);
   endtask

   task automatic apb(input logic w, input logic [31:0] ad, dat);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= dat;
      @(posedge clk);
      penable <= 1'b1;
      // Read data and error are taken at the edge that completes the transfer.
      do @(posedge clk); while (pready !== 1'b1);
      prd  = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic snoop(input logic [31:0] ad);
      @(posedge clk);
      snp_valid <= 1'b1;
      snp_addr  <= ad;
      do @(posedge clk); while (snp_ready !== 1'b1);
      snp_valid <= 1'b0;
      snp_addr  <= ~ad;
   endtask

   // Main sequence; software keeps pages purged and aliases page-aligned.
   // software duties kept
   initial begin
      seed = 32'h00014186;
      {arst_n, psel, penable, pwrite, req_valid, snp_valid, slow} = '0;
      {paddr, pwdata, snp_addr} = '0;
      req = '0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl_reset", {30'h0, CTRL_RST}, prd);
      apb(1'b1, REG_CTRL, 32'hffffffff);
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl_rw", 32'h3, prd);
      apb(1'b1, REG_STATUS, 32'h1);
      chk("ro_write_err", 32'h1, perr);
      apb(1'b0, 32'h10, 32'h0);
      chk("unmapped_rdata", 32'h0, prd);
      chk("unmapped_err", 32'h1, perr);
      apb(1'b1, REG_CTRL, 32'h0);
      d = rnd();
      op(OP_STORE, 4'hc, 0, 32'h100, d, 0, 0, 1, 0, 0);
      op(OP_LOAD, 4'h4, 0, 32'h100, 0, 1, d, 0, 1, 0);
      op(OP_STORE, 4'h8, 0, 32'h2000, d + 1, 0, 0, 1, 0, 0);
      op(OP_LOAD, 4'h8, 0, 32'h2000, 0, 1, d + 1, 0, 0, 0);
      op(OP_STORE, 4'h0, 0, 32'h3004, d + 2, 0, 0, 0, 0, 0);
      op(OP_LOAD, 4'h0, 0, 32'h3004, 0, 1, d + 2, 0, 0, 0);
      op(OP_DCBST, 4'h0, 1, 32'h3004, 0, 0, 0, 0, 0, 0);
      op(OP_DCBST, 4'h0, 0, 32'h3007, 0, 0, 0, 1, 0, 0);
      op(OP_DCBST, 4'h0, 0, 32'h3004, 0, 0, 0, 0, 0, 0);
      chk("mem_word", d + 2, mm.mem[32'h3004]);
      op(OP_STORE, 4'h2, 0, 32'h4008, d + 3, 0, 0, 0, 0, 0);
      op(OP_DCBF, 4'h2, 1, 32'h4008, 0, 0, 0, 0, 0, 0);
      op(OP_DCBF, 4'h2, 0, 32'h400a, 0, 0, 0, 1, 0, 1);
      op(OP_LOAD, 4'h2, 0, 32'h4008, 0, 1, d + 3, 0, 1, 0);
      repeat (2) op(OP_DCBST, 4'h2, 0, 32'h4008, 0, 0, 0, 1, 0, 0);
      op(OP_ICBI, 4'h2, 0, 32'h4008, 0, 0, 0, 0, 0, 1);
      apb(1'b1, REG_CTRL, 32'h2);
      op(OP_ICBI, 4'h2, 0, 32'h4008, 0, 0, 0, 0, 0, 0);
      op(OP_SYNC, 4'h2, 0, 32'h0, 0, 0, 0, 0, 0, 0);
      apb(1'b1, REG_CTRL, 32'h1);
      op(OP_STORE, 4'h0, 0, 32'h3004, d + 4, 0, 0, 1, 0, 0);
      apb(1'b1, REG_CTRL, 32'h0);
      op(OP_STORE, 4'h2, 0, 32'h600c, d + 5, 0, 0, 0, 0, 0);
      snoop(32'h600c);
      op(OP_LOAD, 4'h2, 0, 32'h600c, 0, 1, d + 5, 1, 1, 0);
      for (int i = 0; i < 3; i++) begin
         op(OP_STORE, 4'h5, 0, 32'h5000 + 4 * i, d + i, 0, 0, 1, 0, 0);
      end
      for (int i = 0; i < 3; i++) chk("order", d + i, mm.wlog[mm.wlog.size() - 3 + i]);
      @(posedge clk);
      slow <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         r = rnd();
         a = {20'h00007, r[11:2], 2'h0};
         op(OP_STORE, r[31:28] | 4'h4, 0, a, d, 0, 0, 1, 0, 0);
         op(OP_LOAD, r[27:24] | 4'h4, 0, a, 0, 1, d, 0, 1, 0);
      end
      op(OP_STORE, 4'h2, 0, 32'h8000, d, 0, 0, 0, 0, 0);
      apb(1'b0, REG_WBACKS, 32'h0);
      chk("wbacks", we, prd);
      // Three cacheable hits: two loads and one forced store-through store.
      apb(1'b0, REG_HITS, 32'h0);
      chk("hits", 32'h3, prd);
      chk("notes_left", 32'h0, expq.size());
      tally_and_finish();
   end
endmodule
`default_nettype wire
